// file: hdl/smbus_cfg_pkg.sv
// Constants and carrier types for the two-wire configuration block
package smbus_cfg_pkg;

    // ****************************************
    // Register map and field layout
    // ****************************************
    localparam logic [7:0] CFG_ADDR = 8'hC1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int EN_BIT = 7;
    localparam int INH_BIT = 6;
    localparam int BUSY_BIT = 5;
    localparam int EXT_BIT = 4;
    localparam int TOE_BIT = 3;
    localparam int FTE_BIT = 2;
    localparam int CS_MSB = 1;
    localparam int CS_LSB = 0;

    // ****************************************
    // Clock source codes and timing counts
    // ****************************************
    localparam logic [1:0] CS_TMR0 = 2'h0;
    localparam logic [1:0] CS_TMR1 = 2'h1;
    localparam logic [1:0] CS_TMR2_HI = 2'h2;
    localparam logic [1:0] CS_TMR2_LO = 2'h3;
    localparam logic [3:0] FREE_PERIODS = 4'hA;
    localparam logic [3:0] FREE_DONE = 4'hB;
    localparam logic [3:0] SETUP_NORMAL = 4'h1;
    localparam logic [3:0] SETUP_EXT = 4'hB;
    localparam logic [3:0] HOLD_NORMAL = 4'h3;
    localparam logic [3:0] HOLD_EXT = 4'hC;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        GEN_LOW = 3'b001,
        GEN_HIGH_A = 3'b010,
        GEN_HIGH_B = 3'b100
    } scl_gen_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_type;

    typedef struct packed {
        logic [3:0] setup_clks;
        logic [3:0] hold_clks;
    } sda_timing_type;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic rst;
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl;
        logic sda;
        logic start_tgl;
        logic stop_tgl;
    } link_state_type;

    typedef struct packed {
        logic enable;
        logic inh;
        logic busy;
        logic ext;
        logic toe;
        logic fte;
        logic [1:0] cs;
        logic inh_eff;
        logic [3:0] free_cnt;
        scl_gen_type gen;
        logic [1:0] scl_x;
        logic [1:0] sda_x;
        logic [2:0] start_x;
        logic [2:0] stop_x;
        logic [7:0] rdata;
    } core_state_type;

endpackage

// file: hdl/smbus_config_control.sv
// Configuration, status and bus-watch logic of the first two-wire interface
// Functional notes
// - Interface works only while enable bit 7 is one.
// - When enabled, both bus lines are watched at all times.
// - Slave-inhibit bit 6 suppresses every slave event interrupt.
// - Master event interrupts are untouched by slave-inhibit.
// - Read-only transfer-active bit 5 is set while a transfer runs.
// - Transfer-active clears on STOP or on bus-free timeout.
// - Bit 4 picks normal or extended SDA setup and hold times.
// - With bit 3 set, timeout timer reloads while SCL high, counts while low.
// - In split timer mode only the high byte is held in reload.
// - With bit 2 set, bus is free after SCL,SDA high over 10 periods.
// - Clock source field: 00 T0, 01 T1, 10 T2 high, 11 T2 low.
// - Generated bit rate comes from overflows of the chosen source.
// - As master, one overflow period is the least SCL high and low time.
// - Inhibit takes effect at the next START; current transfer goes on.
// - While inhibited, lines are still watched and addresses get NACK.
`timescale 1ns/1ns
module smbus_config_control (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire smbus_cfg_pkg::sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    input wire logic serial_data_line_in,
    input wire logic [3:0] src_overflow,
    input wire logic master_active,
    input wire logic master_start,
    input wire logic master_event,
    input wire logic slave_event,
    input wire logic timer_split,
    output logic iface_enable,
    output logic transfer_active_flag,
    output logic master_irq,
    output logic slave_irq,
    output logic addr_nack,
    output logic bus_free,
    output logic timer_reload_hi,
    output logic timer_reload_lo,
    output smbus_cfg_pkg::sda_timing_type sda_timing
);
    import smbus_cfg_pkg::*;

    // ****************************************
    // Link domain: line sampling and START/STOP
    // ****************************************
    link_state_type lk;
    link_state_type next_lk;

    // Lines are watched whether or not we take part in the transfer
    always_comb begin
        next_lk = lk;
        next_lk.rst_sync = {lk.rst_sync[0], sys_rst};
        next_lk.rst = lk.rst_sync[1];
        next_lk.scl_sync = {lk.scl_sync[0], serial_clock_line_in};
        next_lk.sda_sync = {lk.sda_sync[0], serial_data_line_in};
        next_lk.scl = lk.scl_sync[1];
        next_lk.sda = lk.sda_sync[1];
        // SDA falling with SCL high marks START, rising marks STOP
        if (lk.scl && lk.scl_sync[1] && lk.sda && !lk.sda_sync[1]) begin
            next_lk.start_tgl = !lk.start_tgl;
        end
        if (lk.scl && lk.scl_sync[1] && !lk.sda && lk.sda_sync[1]) begin
            next_lk.stop_tgl = !lk.stop_tgl;
        end
    end

    // Idle lines reset high so a reset never looks like a START
    always_ff @(posedge link_clk) begin
        if (lk.rst) begin
            lk <= '0;
            lk.rst_sync <= next_lk.rst_sync;
            lk.rst <= next_lk.rst;
            lk.scl_sync <= 2'h3;
            lk.sda_sync <= 2'h3;
            lk.scl <= 1'b1;
            lk.sda <= 1'b1;
        end else begin
            lk <= next_lk;
        end
    end

    // ****************************************
    // Core domain: register, busy, timeouts, SCL
    // ****************************************
    core_state_type s;
    core_state_type next_s;
    logic scl_hi;
    logic sda_hi;
    logic tick;
    logic start_evt;
    logic stop_evt;
    logic free_pulse;
    logic cfg_hit;

    // Crossed levels and toggle edges, read only past the first stage
    assign scl_hi = s.scl_x[1];
    assign sda_hi = s.sda_x[1];
    assign start_evt = s.enable && (s.start_x[2] != s.start_x[1]);
    assign stop_evt = s.enable && (s.stop_x[2] != s.stop_x[1]);
    assign tick = s.enable && src_overflow[s.cs];
    assign cfg_hit = (sfr_req.addr == CFG_ADDR);
    // Free after the eleventh period of both lines high, i.e. more than ten
    assign free_pulse = s.enable && s.fte && scl_hi && sda_hi && tick
        && (s.free_cnt == FREE_PERIODS);

    // Next-state of the whole core side
    always_comb begin
        next_s = s;
        next_s.scl_x = {s.scl_x[0], lk.scl};
        next_s.sda_x = {s.sda_x[0], lk.sda};
        next_s.start_x = {s.start_x[1:0], lk.start_tgl};
        next_s.stop_x = {s.stop_x[1:0], lk.stop_tgl};

        // Free-timeout counter restarts whenever a line drops
        if (!(s.enable && s.fte && scl_hi && sda_hi)) begin
            next_s.free_cnt = 4'h0;
        end else if (tick && s.free_cnt != FREE_DONE) begin
            next_s.free_cnt = s.free_cnt + 4'h1;
        end

        // A start in the same cycle as a clear keeps the flag set
        if (start_evt || (master_start && s.enable)) begin
            next_s.busy = 1'b1;
        end else if (stop_evt || free_pulse || !s.enable) begin
            next_s.busy = 1'b0;
        end

        // Inhibit only bites from the next START on
        if (start_evt) begin
            next_s.inh_eff = s.inh;
        end

        // SCL generator: one period low, two high, so rate is overflow/3
        case (s.gen)
            GEN_LOW: begin
                if (tick) begin
                    next_s.gen = GEN_HIGH_A;
                end
            end
            GEN_HIGH_A: begin
                // High time counts only once the line really is high
                if (tick && scl_hi) begin
                    next_s.gen = GEN_HIGH_B;
                end
            end
            GEN_HIGH_B: begin
                if (tick && master_active) begin
                    next_s.gen = GEN_LOW;
                end
            end
            default: begin
                next_s.gen = GEN_HIGH_B;
            end
        endcase
        if (!s.enable) begin
            next_s.gen = GEN_HIGH_B;
        end

        // Register write; the busy bit is hardware owned
        if (sfr_req.wr && cfg_hit) begin
            next_s.enable = sfr_req.wdata[EN_BIT];
            next_s.inh = sfr_req.wdata[INH_BIT];
            next_s.ext = sfr_req.wdata[EXT_BIT];
            next_s.toe = sfr_req.wdata[TOE_BIT];
            next_s.fte = sfr_req.wdata[FTE_BIT];
            next_s.cs = sfr_req.wdata[CS_MSB:CS_LSB];
        end

        // Read data registered one cycle after the strobe
        next_s.rdata = 8'h00;
        if (sfr_req.rd && cfg_hit) begin
            next_s.rdata[EN_BIT] = s.enable;
            next_s.rdata[INH_BIT] = s.inh;
            next_s.rdata[BUSY_BIT] = s.busy;
            next_s.rdata[EXT_BIT] = s.ext;
            next_s.rdata[TOE_BIT] = s.toe;
            next_s.rdata[FTE_BIT] = s.fte;
            next_s.rdata[CS_MSB:CS_LSB] = s.cs;
        end
    end

    // Synchronous reset clears configuration and releases SCL
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.enable <= CFG_RESET[EN_BIT];
            s.gen <= GEN_HIGH_B;
            s.scl_x <= 2'h3;
            s.sda_x <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sfr_rdata = s.rdata;
    assign iface_enable = s.enable;
    assign transfer_active_flag = s.busy;
    assign bus_free = free_pulse;
    assign master_irq = master_event && s.enable;
    assign slave_irq = slave_event && s.enable && !s.inh_eff;
    assign addr_nack = s.enable && s.inh_eff;
    // Open drain: only ever pulls low
    assign serial_clock_line_out = 1'b0;
    // Gated by enable so a disabling write never leaves SCL held low for a cycle
    assign serial_clock_line_oe = s.enable && (s.gen == GEN_LOW);
    // Timer reload; split mode leaves the low byte free running
    assign timer_reload_hi = s.enable && s.toe && scl_hi;
    assign timer_reload_lo = s.enable && s.toe && scl_hi && !timer_split;
    assign sda_timing.setup_clks = s.ext ? SETUP_EXT : SETUP_NORMAL;
    assign sda_timing.hold_clks = s.ext ? HOLD_EXT : HOLD_NORMAL;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_disabled_quiet: assert property (
        !s.enable |-> !master_irq && !slave_irq && !serial_clock_line_oe)
        else $error("activity while interface disabled");
    a_slave_muted: assert property (
        s.inh_eff && slave_event |-> !slave_irq)
        else $error("slave interrupt while inhibited");
    a_master_passes: assert property (
        s.enable && s.inh_eff && master_event |-> master_irq)
        else $error("master interrupt lost under inhibit");
    a_busy_on_start: assert property (
        start_evt |=> transfer_active_flag)
        else $error("busy not set by start");
    a_busy_cleared: assert property (
        (stop_evt || free_pulse) && !start_evt && !master_start |=> !transfer_active_flag)
        else $error("busy not cleared by stop or free timeout");
    a_hold_select: assert property (
        $rose(s.ext) |-> sda_timing.hold_clks == HOLD_EXT && sda_timing.setup_clks == SETUP_EXT)
        else $error("extended timing not applied");
    a_reload_high: assert property (
        s.enable && s.toe && $past(s.enable && s.toe) && $fell(scl_hi)
        |-> !timer_reload_hi && $past(timer_reload_hi))
        else $error("timer reload does not follow scl");
    a_split_low: assert property (
        timer_split |-> !timer_reload_lo)
        else $error("low byte reloaded in split mode");
    a_free_span: assert property (
        free_pulse |-> $past(scl_hi && sda_hi && s.fte, 1))
        else $error("free timeout without idle lines");
    a_low_period: assert property (
        s.gen == GEN_LOW && !tick && s.enable
        && !(sfr_req.wr && cfg_hit && !sfr_req.wdata[EN_BIT]) |=> serial_clock_line_oe)
        else $error("scl low shorter than one source period");
    a_inhibit_latch: assert property (
        start_evt |=> s.inh_eff == $past(s.inh))
        else $error("inhibit not taken at start");
    a_nack_inhibit: assert property (
        s.enable && s.inh_eff |-> addr_nack && !slave_irq)
        else $error("address not refused while inhibited");
    a_busy_readonly: assert property (
        sfr_req.wr && cfg_hit && !start_evt && !stop_evt && !free_pulse && !master_start
        && s.enable && sfr_req.wdata[EN_BIT] |=> transfer_active_flag == $past(transfer_active_flag))
        else $error("write changed busy flag");

    // Generator, counter and register checks that the scenarios reach less often
    a_high_two_ticks: assert property (
        s.enable && s.gen == GEN_HIGH_A && tick && scl_hi |=> s.gen == GEN_HIGH_B)
        else $error("second high period not entered");

    a_high_stretch: assert property (
        s.enable && s.gen == GEN_HIGH_A && !scl_hi |=> s.gen == GEN_HIGH_A)
        else $error("high time counted while scl held low");

    a_count_selected: assert property (
        s.enable && s.fte && scl_hi && sda_hi && !src_overflow[s.cs] |=> s.free_cnt == $past(s.free_cnt))
        else $error("free counter moved without selected overflow");

    a_free_restart: assert property (
        !(s.enable && s.fte && scl_hi && sda_hi) |=> s.free_cnt == 4'h0)
        else $error("free counter not restarted");

    a_setup_normal: assert property (
        !s.ext |-> sda_timing == {SETUP_NORMAL, HOLD_NORMAL})
        else $error("normal timing not applied");

    a_rdata_quiet: assert property (
        !$past(sfr_req.rd && cfg_hit) |-> sfr_rdata == 8'h00)
        else $error("read data without a read");

    a_split_hold: assert property (
        timer_split && s.enable && s.toe && scl_hi |-> timer_reload_hi && !timer_reload_lo)
        else $error("split reload wrong while scl high");

    a_count_low: assert property (
        !scl_hi |-> !timer_reload_hi && !timer_reload_lo)
        else $error("timer held in reload while scl low");

    a_nack_clear: assert property (
        !s.inh_eff |-> !addr_nack)
        else $error("address refused without inhibit");

    a_inh_hold: assert property (
        !start_evt |=> s.inh_eff == $past(s.inh_eff))
        else $error("inhibit changed outside a start");

    a_enable_follows: assert property (
        sfr_req.wr && cfg_hit |=> iface_enable == $past(sfr_req.wdata[EN_BIT]))
        else $error("enable bit not written");

endmodule // smbus_config_control

// file: tb/smbus_peer_model.sv
// Behavioural peer master that drives the two bus lines
`timescale 1ns/1ns
module smbus_peer_model (
    input wire logic link_clk,
    input wire logic serial_clock_line_oe,
    output logic serial_clock_line,
    output logic serial_data_line
);
    logic scl_low;
    logic sda_low;
    // Open-drain lines with pull-ups: whoever pulls low wins
    assign serial_clock_line = !(scl_low || serial_clock_line_oe);
    assign serial_data_line = !sda_low;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Three link periods per level, above the two the sampler needs
    task automatic hold_level();
        repeat (3) @(posedge link_clk);
    endtask
    // SDA falls while SCL is high, then SCL goes low
    task automatic send_start();
        sda_low = 1'b1;
        hold_level();
        scl_low = 1'b1;
        hold_level();
    endtask
    // SDA rises while SCL is high
    task automatic send_stop();
        sda_low = 1'b1;
        hold_level();
        scl_low = 1'b0;
        hold_level();
        sda_low = 1'b0;
        hold_level();
    endtask
    // Both lines back high with no STOP, so only a timeout frees the bus
    task automatic leave_high();
        sda_low = 1'b0;
        hold_level();
        scl_low = 1'b0;
        hold_level();
    endtask
    task automatic pull_clock(input logic v);
        scl_low = v;
        hold_level();
    endtask
endmodule // smbus_peer_model

// file: tb/tb_smbus_config_control.sv
// Self-checking bench for the two-wire configuration block
`timescale 1ns/1ns
module tb_smbus_config_control;
    import smbus_cfg_pkg::*;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    sfr_req_type sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic scl;
    logic sda;
    logic scl_oe;
    logic scl_out;
    logic bus_free_p;
    logic [3:0] src_overflow = 4'h0;
    logic master_active = 1'b0;
    logic master_start = 1'b0;
    logic master_event = 1'b0;
    logic slave_event = 1'b0;
    logic timer_split = 1'b0;
    logic iface_enable;
    logic busy;
    logic master_irq;
    logic slave_irq;
    logic addr_nack;
    logic reload_hi;
    logic reload_lo;
    sda_timing_type sda_timing;
    int miscompares = 0;
    int n_tests = 0;
    logic [7:0] d;

    // ****************************************
    // Clocks, design and peer
    // ****************************************
    always #5 core_clk = ~core_clk;
    // Odd start offset keeps the link clock unrelated in phase
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    smbus_config_control uut (.core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .serial_clock_line_in(scl),
        .serial_clock_line_out(scl_out), .serial_clock_line_oe(scl_oe),
        .serial_data_line_in(sda), .src_overflow(src_overflow),
        .master_active(master_active), .master_start(master_start),
        .master_event(master_event), .slave_event(slave_event),
        .timer_split(timer_split), .iface_enable(iface_enable),
        .transfer_active_flag(busy), .master_irq(master_irq), .slave_irq(slave_irq),
        .addr_nack(addr_nack), .bus_free(bus_free_p), .timer_reload_hi(reload_hi),
        .timer_reload_lo(reload_lo), .sda_timing(sda_timing));
    smbus_peer_model peer (.link_clk(link_clk), .serial_clock_line_oe(scl_oe),
        .serial_clock_line(scl), .serial_data_line(sda));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic wrap_up();
        $display("mismatches=%0d comparisons=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        sfr_req.addr = a;
        sfr_req.wdata = v;
        sfr_req.wr = 1'b1;
        @(negedge core_clk);
        sfr_req.wr = 1'b0;
    endtask
    // Read data stands for the one cycle after the taking edge
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge core_clk);
        sfr_req.addr = a;
        sfr_req.rd = 1'b1;
        @(negedge core_clk);
        sfr_req.rd = 1'b0;
        v = sfr_rdata;
    endtask
    // Line edges cross two clock domains, so the wait is bounded, not fixed
    task automatic wait_busy(input logic exp);
        int i;
        for (i = 0; i < 300 && busy !== exp; i++) @(negedge core_clk);
        if (i == 300) begin
            miscompares++;
            wrap_up();
        end else begin
            chk(busy, exp);
        end
    endtask
    // Both events at once; irq outputs and NACK level are combinational here
    task automatic events(input logic [2:0] exp);
        @(negedge core_clk);
        master_event = 1'b1;
        slave_event = 1'b1;
        #1;
        chk({master_irq, slave_irq, addr_nack}, exp);
        @(negedge core_clk);
        master_event = 1'b0;
        slave_event = 1'b0;
    endtask
    task automatic tick(input int idx, input int n);
        repeat (n) begin
            @(negedge core_clk);
            src_overflow[idx] = 1'b1;
            @(negedge core_clk);
            src_overflow = 4'h0;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        reg_rd(8'hC1, d);
        chk(d, 8'h00);
        reg_wr(8'hC1, 8'hFF);
        reg_rd(8'hC1, d);
        chk(d, 8'hDF);
        chk(iface_enable, 1'b1);
        reg_rd(8'hC2, d);
        chk(d, 8'h00);
        reg_wr(8'hC1, 8'h90);
        chk(sda_timing, 8'hBC);
        reg_wr(8'hC1, 8'h80);
        chk(sda_timing, 8'h13);
    endtask
    task automatic t_irq();
        events(3'b110);
        reg_wr(8'hC1, 8'hC0);
        events(3'b110);
        peer.send_start();
        wait_busy(1'b1);
        events(3'b101);
        peer.send_stop();
        wait_busy(1'b0);
        reg_wr(8'hC1, 8'h00);
        events(3'b000);
        peer.send_start();
        idle(60);
        chk(busy, 1'b0);
        peer.send_stop();
    endtask
    // A transfer stalls with SCL low; the timer handler restarts the link
    task automatic t_reload();
        reg_wr(8'hC1, 8'h88);
        idle(20);
        chk({reload_hi, reload_lo}, 2'b11);
        timer_split = 1'b1;
        idle(1);
        chk({reload_hi, reload_lo}, 2'b10);
        peer.send_start();
        wait_busy(1'b1);
        idle(10);
        chk({reload_hi, reload_lo}, 2'b00);
        reg_wr(8'hC1, 8'h08);
        reg_wr(8'hC1, 8'h88);
        chk(busy, 1'b0);
        peer.leave_high();
        timer_split = 1'b0;
    endtask
    // Only ticks of the selected source may count toward the free timeout
    task automatic t_free();
        for (int cs = 0; cs < 4; cs++) begin
            reg_wr(8'hC1, 8'h84 | 8'(cs));
            peer.send_start();
            peer.leave_high();
            wait_busy(1'b1);
            idle(40);
            tick(cs ^ 1, 12);
            chk(busy, 1'b1);
            tick(cs, 10);
            chk(busy, 1'b1);
            @(negedge core_clk);
            src_overflow[cs] = 1'b1;
            #1;
            chk(bus_free_p, 1'b1);
            @(negedge core_clk);
            src_overflow = 4'h0;
            idle(3);
            chk(busy, 1'b0);
        end
    endtask
    // Generated SCL: one selected-source period low, two high
    task automatic t_scl_gen();
        reg_wr(8'hC1, 8'h81);
        master_active = 1'b1;
        tick(0, 2);
        chk(scl_oe, 1'b0);
        tick(1, 1);
        chk({scl_oe, scl_out}, 2'b10);
        idle(40);
        chk(scl_oe, 1'b1);
        tick(1, 1);
        chk(scl_oe, 1'b0);
        idle(40);
        tick(1, 1);
        chk(scl_oe, 1'b0);
        tick(1, 1);
        chk(scl_oe, 1'b1);
        master_active = 1'b0;
        tick(1, 1);
        idle(40);
        tick(1, 2);
        chk(scl_oe, 1'b0);
        @(negedge core_clk);
        master_start = 1'b1;
        @(negedge core_clk);
        master_start = 1'b0;
        chk(busy, 1'b1);
        reg_wr(8'hC1, 8'h00);
        idle(1);
        chk({busy, scl_oe}, 2'b00);
    endtask

    // Reset for six core cycles; the link side takes it through three link
    // flops, so the first request waits until that side has settled
    initial begin
        idle(6);
        sys_rst = 1'b0;
        idle(26);
        t_regs();
        t_irq();
        t_reload();
        t_free();
        t_scl_gen();
        wrap_up();
    end
endmodule // tb_smbus_config_control
